// ### hw/tweb_defines.svh
// Constants of the two-wire EEPROM bus slave.
// Assumes inclusion by bare name from the design files.
`ifndef TWEB_DEFINES_SVH
`define TWEB_DEFINES_SVH
`define TWEB_ADDR_W 15
`define TWEB_MEM_DEPTH 32768
`define TWEB_PAGE_W 6
`define TWEB_PAGE_BYTES 64
`define TWEB_DEV_TYPE 4'hA
`define TWEB_BIT_LAST 4'h8
`define TWEB_BIT_TX_LAST 4'h7
`define TWEB_CLK_NS 20
`define TWEB_WR_TIME_NS 5000000
`define TWEB_WR_CYCLES (`TWEB_WR_TIME_NS / `TWEB_CLK_NS)
`define TWEB_WR_CNT_W 18
`endif

// ### hw/tweb_pkg.sv
// Types of the two-wire EEPROM bus slave.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none
package tweb_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_RX = 3'b001,
      ST_ACK = 3'b010,
      ST_TX = 3'b011,
      ST_MACK = 3'b100
   } tweb_state_t;

   typedef struct packed {
      logic scl;
      logic sda;
      logic wp;
      logic [2:0] sel;
   } tweb_pins_t;
endpackage : tweb_pkg

`default_nettype wire

// ### hw/tweb_slave.sv
// Two-wire serial EEPROM slave: protocol engine, page buffer and array.
// Assumes core_clk far faster than the serial clock; pins are asynchronous.
//
// Operation
// - Sample data on serial clock rise, launch outgoing data on its fall.
// - Data line is open drain: pull low or release only.
// - Three strapped select pins give up to eight distinct devices.
// - Respond only when sent select bits equal the strapped pins.
// - Unconnected select pin counts as low.
// - Write-protect high at the stop blocks that array write; low allows writes.
// - Unconnected write-protect counts as low, writes enabled.
// - Array is 512 pages of 64 bytes.
// - Random access uses a 15-bit word address.
// - Data bits change only while the serial clock is low.
// - Data change with clock high is start or stop, never data.
// - Data fall with clock high is start; commands need one.
// - Data rise with clock high is stop, ending the transfer.
// - Stop after a read enters standby.
// - Every address and data item is an 8-bit word.
// - Device pulls data low on the ninth clock after each word it receives.
// - Standby at power-up and after stop once internal work ends.
// - Start, nine clocks, start, stop recovers the interface.
// - Internal write lasts at most 5 ms after the stop.
// - Last device address bit high means read, low means write.
// - Select mismatch gives no acknowledge and back to standby.
// - No device address acknowledge while the write cycle runs.
// - Multi-byte write increments low six address bits only.
`timescale 1ns/100ps
`default_nettype none
`include "tweb_defines.svh"

module tweb_slave #(
   parameter int unsigned WR_CYCLES = `TWEB_WR_CYCLES
) (
   // Clock and reset
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic clk_en,
   // Bus and strap pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   input wire logic write_protect,
   input wire logic [2:0] device_select_pins,
   // Status
   output logic standby
);
   tweb_pkg::tweb_pins_t pin_m_reg, pin_m_next;
   tweb_pkg::tweb_pins_t pin_s_reg, pin_s_next;
   tweb_pkg::tweb_pins_t pin_p_reg, pin_p_next;
   tweb_pkg::tweb_state_t state_reg, state_next;
   logic [3:0] bit_cnt_reg, bit_cnt_next;
   logic [7:0] shift_reg, shift_next;
   logic [1:0] byte_idx_reg, byte_idx_next;
   logic rw_reg, rw_next;
   logic mack_ok_reg, mack_ok_next;
   logic sda_oe_reg, sda_oe_next;
   logic standby_reg, standby_next;
   logic [`TWEB_ADDR_W-1:0] addr_reg, addr_next;
   logic [6:0] addr_hi_reg, addr_hi_next;
   logic [7:0] page_reg [`TWEB_PAGE_BYTES];
   logic [7:0] page_next [`TWEB_PAGE_BYTES];
   logic [`TWEB_PAGE_BYTES-1:0] mask_reg, mask_next;
   logic wr_pend_reg, wr_pend_next;
   logic busy_reg, busy_next;
   logic [`TWEB_WR_CNT_W-1:0] wr_cnt_reg, wr_cnt_next;
   logic [7:0] mem_reg [`TWEB_MEM_DEPTH];
   logic mem_we;
   logic [`TWEB_ADDR_W-1:0] mem_wa;
   logic [7:0] mem_wd;
   logic [7:0] rd_byte;
   logic scl_rise, scl_fall, start_ev, stop_ev, sel_match;

   // Two-flop synchronisers; a third stage only for edge finding
   always_comb begin
      pin_m_next.scl = scl_in;
      pin_m_next.sda = sda_in;
      pin_m_next.wp = write_protect;
      pin_m_next.sel = device_select_pins;
      pin_s_next = pin_m_reg;
      pin_p_next = pin_s_reg;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         pin_m_reg <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
         pin_s_reg <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
         pin_p_reg <= '{scl: 1'h1, sda: 1'h1, wp: 1'h0, sel: 3'h0};
      end else if (clk_en) begin
         pin_m_reg <= pin_m_next;
         pin_s_reg <= pin_s_next;
         pin_p_reg <= pin_p_next;
      end
   end

   assign scl_rise = pin_s_reg.scl & ~pin_p_reg.scl;
   assign scl_fall = ~pin_s_reg.scl & pin_p_reg.scl;
   // Clock high on both samples: a data edge here is framing
   assign start_ev = pin_s_reg.scl & pin_p_reg.scl & pin_p_reg.sda & ~pin_s_reg.sda;
   assign stop_ev = pin_s_reg.scl & pin_p_reg.scl & ~pin_p_reg.sda & pin_s_reg.sda;
   assign sel_match = (shift_reg[7:4] == `TWEB_DEV_TYPE) &&
                      (shift_reg[3:1] == pin_s_reg.sel);
   assign rd_byte = mem_reg[addr_reg];
   assign mem_wa = {addr_reg[`TWEB_ADDR_W-1:`TWEB_PAGE_W], wr_cnt_reg[`TWEB_PAGE_W-1:0]};
   assign mem_wd = page_reg[wr_cnt_reg[`TWEB_PAGE_W-1:0]];

   always_comb begin
      state_next = state_reg;
      bit_cnt_next = bit_cnt_reg;
      shift_next = shift_reg;
      byte_idx_next = byte_idx_reg;
      rw_next = rw_reg;
      mack_ok_next = mack_ok_reg;
      sda_oe_next = sda_oe_reg;
      addr_next = addr_reg;
      addr_hi_next = addr_hi_reg;
      page_next = page_reg;
      mask_next = mask_reg;
      wr_pend_next = wr_pend_reg;
      busy_next = busy_reg;
      wr_cnt_next = wr_cnt_reg;
      mem_we = 1'h0;
      // Commit one buffered byte per cycle, then wait out the write time
      if (busy_reg) begin
         if (wr_cnt_reg < `TWEB_WR_CNT_W'(`TWEB_PAGE_BYTES)) begin
            mem_we = mask_reg[wr_cnt_reg[`TWEB_PAGE_W-1:0]];
         end
         if (wr_cnt_reg == `TWEB_WR_CNT_W'(WR_CYCLES - 1)) begin
            busy_next = 1'h0;
            wr_cnt_next = '0;
         end else begin
            wr_cnt_next = wr_cnt_reg + `TWEB_WR_CNT_W'(1);
         end
      end
      if (start_ev) begin
         // Any start restarts framing; also ends the recovery sequence
         state_next = tweb_pkg::ST_RX;
         bit_cnt_next = 4'h0;
         byte_idx_next = 2'h0;
         sda_oe_next = 1'h0;
         wr_pend_next = 1'h0;
      end else if (stop_ev) begin
         state_next = tweb_pkg::ST_IDLE;
         sda_oe_next = 1'h0;
         wr_pend_next = 1'h0;
         if (wr_pend_reg && !pin_s_reg.wp && !busy_reg) begin
            busy_next = 1'h1;
            wr_cnt_next = '0;
         end
      end else begin
         case (state_reg)
            tweb_pkg::ST_RX: begin
               if (scl_rise && bit_cnt_reg != `TWEB_BIT_LAST) begin
                  shift_next = {shift_reg[6:0], pin_s_reg.sda};
                  bit_cnt_next = bit_cnt_reg + 4'h1;
               end else if (scl_fall && bit_cnt_reg == `TWEB_BIT_LAST) begin
                  state_next = tweb_pkg::ST_ACK;
                  sda_oe_next = 1'h1;
                  case (byte_idx_reg)
                     2'h0: begin
                        // Busy hides the device while the array updates
                        if (sel_match && !busy_reg) begin
                           rw_next = shift_reg[0];
                           byte_idx_next = 2'h1;
                        end else begin
                           state_next = tweb_pkg::ST_IDLE;
                           sda_oe_next = 1'h0;
                        end
                     end
                     2'h1: begin
                        addr_hi_next = shift_reg[6:0];
                        byte_idx_next = 2'h2;
                     end
                     2'h2: begin
                        addr_next = {addr_hi_reg, shift_reg};
                        mask_next = '0;
                        byte_idx_next = 2'h3;
                     end
                     default: begin
                        page_next[addr_reg[`TWEB_PAGE_W-1:0]] = shift_reg;
                        mask_next[addr_reg[`TWEB_PAGE_W-1:0]] = 1'h1;
                        addr_next[`TWEB_PAGE_W-1:0] =
                           addr_reg[`TWEB_PAGE_W-1:0] + `TWEB_PAGE_W'(1);
                        wr_pend_next = 1'h1;
                     end
                  endcase
               end
            end
            tweb_pkg::ST_ACK: begin
               if (scl_fall) begin
                  bit_cnt_next = 4'h0;
                  if (rw_reg) begin
                     state_next = tweb_pkg::ST_TX;
                     shift_next = rd_byte;
                     sda_oe_next = ~rd_byte[7];
                  end else begin
                     state_next = tweb_pkg::ST_RX;
                     sda_oe_next = 1'h0;
                  end
               end
            end
            tweb_pkg::ST_TX: begin
               if (scl_fall) begin
                  if (bit_cnt_reg == `TWEB_BIT_TX_LAST) begin
                     state_next = tweb_pkg::ST_MACK;
                     sda_oe_next = 1'h0;
                     addr_next = addr_reg + `TWEB_ADDR_W'(1);
                  end else begin
                     shift_next = {shift_reg[6:0], 1'h0};
                     sda_oe_next = ~shift_reg[6];
                     bit_cnt_next = bit_cnt_reg + 4'h1;
                  end
               end
            end
            tweb_pkg::ST_MACK: begin
               if (scl_rise) begin
                  mack_ok_next = ~pin_s_reg.sda;
               end else if (scl_fall) begin
                  // No master acknowledge ends the read; wait for stop
                  if (mack_ok_reg) begin
                     state_next = tweb_pkg::ST_TX;
                     bit_cnt_next = 4'h0;
                     shift_next = rd_byte;
                     sda_oe_next = ~rd_byte[7];
                  end else begin
                     state_next = tweb_pkg::ST_IDLE;
                  end
               end
            end
            default: begin
               sda_oe_next = 1'h0;
            end
         endcase
      end
      standby_next = (state_next == tweb_pkg::ST_IDLE) && !busy_next;
   end

   always_ff @(posedge core_clk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= tweb_pkg::ST_IDLE;
         bit_cnt_reg <= 4'h0;
         shift_reg <= 8'h00;
         byte_idx_reg <= 2'h0;
         rw_reg <= 1'h0;
         mack_ok_reg <= 1'h0;
         sda_oe_reg <= 1'h0;
         standby_reg <= 1'h1;
         addr_reg <= '0;
         addr_hi_reg <= 7'h00;
         mask_reg <= '0;
         wr_pend_reg <= 1'h0;
         busy_reg <= 1'h0;
         wr_cnt_reg <= '0;
         for (int i = 0; i < `TWEB_PAGE_BYTES; i++) begin
            page_reg[i] <= 8'h00;
         end
      end else if (clk_en) begin
         state_reg <= state_next;
         bit_cnt_reg <= bit_cnt_next;
         shift_reg <= shift_next;
         byte_idx_reg <= byte_idx_next;
         rw_reg <= rw_next;
         mack_ok_reg <= mack_ok_next;
         sda_oe_reg <= sda_oe_next;
         standby_reg <= standby_next;
         addr_reg <= addr_next;
         addr_hi_reg <= addr_hi_next;
         mask_reg <= mask_next;
         wr_pend_reg <= wr_pend_next;
         busy_reg <= busy_next;
         wr_cnt_reg <= wr_cnt_next;
         page_reg <= page_next;
      end
   end

   // Array keeps contents across reset, as nonvolatile storage would
   always_ff @(posedge core_clk) begin
      if (clk_en && mem_we) begin
         mem_reg[mem_wa] <= mem_wd;
      end
   end

   assign sda_out = 1'h0;
   assign sda_oe = sda_oe_reg;
   assign standby = standby_reg;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (sys_rst);

   sequence s_dev_done;
      clk_en && state_reg == tweb_pkg::ST_RX && byte_idx_reg == 2'h0 &&
      scl_fall && bit_cnt_reg == `TWEB_BIT_LAST && !start_ev && !stop_ev;
   endsequence

   sequence s_wp_stop;
      clk_en && stop_ev && wr_pend_reg && pin_s_reg.wp && !busy_reg;
   endsequence

   a_pin_open_drain: assert property (sda_out == 1'h0)
      else $error("data line driven high");
   a_start_frame: assert property (clk_en && start_ev |=>
      state_reg == tweb_pkg::ST_RX && bit_cnt_reg == 4'h0 && !sda_oe)
      else $error("start did not restart framing");
   a_stop_idle: assert property (clk_en && stop_ev |=>
      state_reg == tweb_pkg::ST_IDLE && !sda_oe)
      else $error("stop did not end transfer");
   a_sel_nack: assert property (s_dev_done ##0 (!sel_match || busy_reg) |=>
      !sda_oe && state_reg == tweb_pkg::ST_IDLE)
      else $error("acknowledged without selection");
   a_sel_ack: assert property (s_dev_done ##0 (sel_match && !busy_reg) |=>
      sda_oe && rw_reg == $past(shift_reg[0]))
      else $error("selected device did not acknowledge");
   a_busy_nack: assert property (busy_reg && state_reg == tweb_pkg::ST_ACK |->
      byte_idx_reg != 2'h1 || $past(byte_idx_reg) == 2'h1)
      else $error("device address acknowledged while busy");
   a_ack_ninth: assert property (state_reg == tweb_pkg::ST_ACK |-> sda_oe)
      else $error("acknowledge not driven");
   a_launch_fall: assert property ($changed(sda_oe) |->
      $past(scl_fall) || $past(start_ev) || $past(stop_ev))
      else $error("data launched away from clock fall");
   a_ack_release: assert property (clk_en && state_reg == tweb_pkg::ST_ACK &&
      scl_fall && !rw_reg && !start_ev && !stop_ev |=> !sda_oe)
      else $error("data line held after acknowledge");
   a_wp_blocks: assert property (s_wp_stop |=> !busy_reg ##1 !busy_reg)
      else $error("write started while protected");
   a_page_wrap: assert property (clk_en && state_reg == tweb_pkg::ST_RX &&
      byte_idx_reg == 2'h3 && scl_fall && bit_cnt_reg == `TWEB_BIT_LAST &&
      !start_ev && !stop_ev |=>
      addr_reg[`TWEB_ADDR_W-1:`TWEB_PAGE_W] == $past(addr_reg[`TWEB_ADDR_W-1:`TWEB_PAGE_W]) &&
      addr_reg[`TWEB_PAGE_W-1:0] == $past(addr_reg[`TWEB_PAGE_W-1:0]) + `TWEB_PAGE_W'(1))
      else $error("write address left its page");
   a_write_time: assert property (busy_reg |-> wr_cnt_reg < `TWEB_WR_CNT_W'(WR_CYCLES))
      else $error("write cycle overran");
   a_standby: assert property (standby |-> !busy_reg && state_reg == tweb_pkg::ST_IDLE)
      else $error("standby during activity");
endmodule : tweb_slave

`default_nettype wire

// ### verification/tweb_master_model.sv
// Behavioural two-wire bus master facing the EEPROM slave.
// Assumes a 50 MHz core_clk; a 160 ns serial period; an open-drain data line pulled up outside.
`timescale 1ns/100ps
`default_nettype none

module tweb_master_model (
   // Clock
   input wire logic core_clk,
   // Bus, sda_drv high means released
   output logic scl,
   output logic sda_drv,
   input wire logic sda_wire
);
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Quarter of the serial period, moved just after a core edge
   task automatic q();
      repeat (2) @(posedge core_clk);
      #1;
   endtask : q

   // One clock from low to low; data moves mid-low, sampled at the end of high
   task automatic bit_cyc(input logic b, output logic s);
      q();
      sda_drv = b;
      q();
      scl = 1'b1;
      q();
      q();
      s = sda_wire;
      scl = 1'b0;
   endtask : bit_cyc

   // Also serves as repeated start; cannot win while the slave pulls low
   task automatic start();
      q();
      sda_drv = 1'b1;
      q();
      scl = 1'b1;
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b0;
   endtask : start

   // Serial clock then stands still high outside frames
   task automatic stop();
      q();
      sda_drv = 1'b0;
      q();
      scl = 1'b1;
      q();
      q();
      sda_drv = 1'b1;
      q();
      q();
   endtask : stop

   // Clock goes low with data high: no start is made
   task automatic park_low();
      q();
      scl = 1'b0;
   endtask : park_low

   task automatic write_byte(input logic [7:0] b, output logic acked);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(b[i], s);
      end
      bit_cyc(1'b1, s);
      acked = !s;
   endtask : write_byte

   task automatic read_byte(output logic [7:0] d, input logic last);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_cyc(1'b1, d[i]);
      end
      bit_cyc(last, s);
   endtask : read_byte
endmodule : tweb_master_model

`default_nettype wire

// ### verification/twowire_eeprom_bus_slave_tb_top.sv
// Self-checking bench for the two-wire EEPROM slave.
// Assumes tweb_slave and tweb_master_model are compiled first.
`timescale 1ns/100ps
`default_nettype none

module twowire_eeprom_bus_slave_tb_top;
   localparam int unsigned WR_CYC = 200;
   logic core_clk;
   logic sys_rst;
   logic clk_en;
   logic scl;
   logic sda_drv;
   logic sda_wire;
   logic sda_out;
   logic sda_oe;
   logic write_protect;
   logic [2:0] device_select_pins;
   logic standby;
   int mismatches;
   int check_count;

   // Wired-AND with the pull-up
   assign sda_wire = sda_drv & !(sda_oe & !sda_out);

   tweb_slave #(.WR_CYCLES(WR_CYC)) tweb_slave_inst (
      .core_clk(core_clk), .sys_rst(sys_rst), .clk_en(clk_en), .scl_in(scl),
      .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe), .write_protect(write_protect),
      .device_select_pins(device_select_pins), .standby(standby));

   tweb_master_model tweb_master_model_inst (
      .core_clk(core_clk), .scl(scl), .sda_drv(sda_drv), .sda_wire(sda_wire));

   initial begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end

   task automatic report_and_stop();
      if (mismatches == 0 && check_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : report_and_stop

   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      check_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   task automatic tick(input int n);
      repeat (n) @(posedge core_clk);
      #1;
   endtask : tick

   function automatic logic [7:0] dev(input logic rd);
      return {4'hA, device_select_pins, rd};
   endfunction : dev

   task automatic send(input logic [7:0] b, input logic exp_ack);
      logic a;
      tweb_master_model_inst.write_byte(b, a);
      check("ack", {7'h00, a}, {7'h00, exp_ack});
   endtask : send

   task automatic write_at(input logic [14:0] a, input logic [7:0] d[$]);
      tweb_master_model_inst.start();
      send(dev(1'b0), 1'b1);
      send({1'b0, a[14:8]}, 1'b1);
      send(a[7:0], 1'b1);
      foreach (d[i]) send(d[i], 1'b1);
      tweb_master_model_inst.stop();
   endtask : write_at

   task automatic read_chk(input logic [14:0] a, input logic [7:0] e[$]);
      logic [7:0] d;
      tweb_master_model_inst.start();
      send(dev(1'b0), 1'b1);
      send({1'b0, a[14:8]}, 1'b1);
      send(a[7:0], 1'b1);
      tweb_master_model_inst.start();
      send(dev(1'b1), 1'b1);
      foreach (e[i]) begin
         tweb_master_model_inst.read_byte(d, i == e.size() - 1);
         check("read data", d, e[i]);
      end
      tweb_master_model_inst.stop();
   endtask : read_chk

   task automatic wait_idle();
      for (int n = 0; n < WR_CYC + 100 && standby !== 1'b1; n++) tick(1);
      check("standby after write", {7'h00, standby}, 8'h01);
   endtask : wait_idle

   task automatic t_reset();
      check("idle oe", {7'h00, sda_oe}, 8'h00);
      check("idle standby", {7'h00, standby}, 8'h01);
      check("open drain level", {7'h00, sda_out}, 8'h00);
   endtask : t_reset

   // Every strap value; a word for a neighbour is refused
   task automatic t_select();
      for (int i = 0; i < 8; i++) begin
         device_select_pins = 3'(i);
         tick(4);
         tweb_master_model_inst.start();
         send(dev(1'b0), 1'b1);
         tweb_master_model_inst.start();
         send({4'hA, device_select_pins ^ 3'b001, 1'b0}, 1'b0);
         tweb_master_model_inst.stop();
         check("standby on mismatch", {7'h00, standby}, 8'h01);
      end
   endtask : t_select

   task automatic t_write_busy();
      device_select_pins = 3'b101;
      tick(4);
      write_at(15'h0155, '{8'h5A, 8'hA5});
      tick(4);
      check("standby in write", {7'h00, standby}, 8'h00);
      check("released after ack", {7'h00, sda_oe}, 8'h00);
      // Clock enable low must hold the write cycle where it stands
      clk_en = 1'b0;
      tick(WR_CYC + 20);
      check("frozen write", {7'h00, standby}, 8'h00);
      clk_en = 1'b1;
      tweb_master_model_inst.start();
      send(dev(1'b0), 1'b0);
      tweb_master_model_inst.stop();
      wait_idle();
      read_chk(15'h0155, '{8'h5A, 8'hA5});
      tick(4);
      check("standby after read", {7'h00, standby}, 8'h01);
   endtask : t_write_busy

   task automatic t_wp();
      write_protect = 1'b1;
      tick(4);
      write_at(15'h0155, '{8'hC3});
      tick(4);
      check("no write cycle", {7'h00, standby}, 8'h01);
      write_protect = 1'b0;
      tick(4);
      read_chk(15'h0155, '{8'h5A});
   endtask : t_wp

   // Break a read mid-byte while the slave may hold data low
   task automatic t_recover();
      logic s;
      tweb_master_model_inst.start();
      send(dev(1'b1), 1'b1);
      for (int i = 0; i < 3; i++) tweb_master_model_inst.bit_cyc(1'b1, s);
      tweb_master_model_inst.start();
      for (int i = 0; i < 9; i++) tweb_master_model_inst.bit_cyc(1'b1, s);
      tweb_master_model_inst.start();
      tweb_master_model_inst.stop();
      read_chk(15'h0156, '{8'hA5});
   endtask : t_recover

   task automatic t_nostart();
      tweb_master_model_inst.park_low();
      send(dev(1'b0), 1'b0);
      tweb_master_model_inst.stop();
   endtask : t_nostart

   task automatic t_page();
      device_select_pins = 3'b000;
      tick(4);
      write_at(15'h123E, '{8'h11, 8'h22, 8'h33});
      wait_idle();
      read_chk(15'h123E, '{8'h11, 8'h22});
      read_chk(15'h1200, '{8'h33});
   endtask : t_page

   initial begin
      sys_rst = 1'b1;
      clk_en = 1'b1;
      write_protect = 1'b0;
      device_select_pins = 3'b000;
      mismatches = 0;
      check_count = 0;
      tick(5);
      sys_rst = 1'b0;
      tick(2);
      t_reset();
      t_select();
      t_write_busy();
      t_wp();
      t_recover();
      t_nostart();
      t_page();
      report_and_stop();
   end

   // Run needs about 110 us of bus traffic
   initial begin
      #600000;
      mismatches++;
      report_and_stop();
   end
endmodule : twowire_eeprom_bus_slave_tb_top

`default_nettype wire
